// ### verilog/map_defines.vh
// Register map, field positions and timing constants of the audio port.
// Assumes a 12-bit byte address on a 32-bit APB slave port.
`ifndef MAP_DEFINES_VH
`define MAP_DEFINES_VH
`define MAP_OFF_CTRL    12'h000
`define MAP_OFF_TXCK    12'h004
`define MAP_OFF_RXCK    12'h008
`define MAP_OFF_SER     12'h00c
`define MAP_OFF_TXCHK   12'h010
`define MAP_OFF_RXCHK   12'h014
`define MAP_OFF_STAT    12'h018
`define MAP_OFF_MUTE    12'h01c
`define MAP_OFF_IEN     12'h020
`define MAP_BUF_PAGE    6'h04
`define MAP_DP_PAGE     4'h2
`define MAP_CK_DIV      11:0
`define MAP_CK_INTB     12
`define MAP_CK_BPOL     13
`define MAP_CK_INTF     14
`define MAP_CK_FLEN     15
`define MAP_CK_FPOL     16
`define MAP_CK_SLOTS    21:17
`define MAP_CK_SIZE     24:22
`define MAP_CK_DLY      26:25
`define MAP_CK_MASK     32'h07ff_ffff
`define MAP_CHK_MIN     7:0
`define MAP_CHK_MAX     15:8
`define MAP_CHK_CNT     23:16
`define MAP_SER_TX      2'h1
`define MAP_SER_RX      2'h2
`define MAP_ST_TXUR     0
`define MAP_ST_RXOR     1
`define MAP_ST_TXPR     2
`define MAP_ST_RXPR     3
`define MAP_ST_TXCK     4
`define MAP_ST_RXCK     5
`define MAP_MUTE_LVL    6
`define MAP_RST_MUTE    7'h40
`define MAP_RST_CHK     16'hff00
`define MAP_WIN_LAST    5'h1f
`endif

// ### verilog/map_bufmem.v
// Sixteen-word store for the serializer data buffers.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/10ps
module map_bufmem (
   input  wire        clk_in,
   input  wire        we_in,
   input  wire [3:0]  waddr_in,
   input  wire [31:0] wdata_in,
   input  wire [3:0]  raddr_in,
   output reg  [31:0] rdata_out
);
   reg [31:0] mem [0:15];

   // Write port and registered read port.
   always @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
   end
endmodule

// ### verilog/map_clkgen.v
// Bit clock divider, frame sync generator and slot sequencer, one direction.
// Assumes master clock edges arrive as one-cycle enables on the system clock.
`timescale 1ns/10ps
`include "map_defines.vh"
module map_clkgen (
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire        en_in,
   input  wire        mclk_edge_in,
   input  wire [31:0] cfg_in,
   input  wire        go_in,
   input  wire        bclk_pin_in,
   input  wire        fs_pin_in,
   output reg         bclk_out,
   output reg         bclk_oe_n_out,
   output reg         fs_out,
   output reg         fs_oe_n_out,
   output reg         slot_evt_out,
   output reg         err_out
);
   reg  [2:0]  bs;
   reg  [2:0]  fsy;
   reg         bf;
   reg         bf_d;
   reg         ff;
   reg         fa_d;
   reg  [11:0] dcnt;
   reg  [9:0]  pos;
   reg  [5:0]  bitc;
   reg         run;
   reg         lock;
   wire        pol  = cfg_in[`MAP_CK_BPOL];
   wire        intf = cfg_in[`MAP_CK_INTF];
   wire [5:0]  size = {1'b0, cfg_in[`MAP_CK_SIZE], 2'b00} + 6'h08;
   wire [5:0]  slots = {1'b0, cfg_in[`MAP_CK_SLOTS]} + 6'h01;
   wire [11:0] total = {6'h00, slots} * {6'h00, size};
   wire [9:0]  last = total[9:0] - 10'h001;
   wire [5:0]  dly = {4'h0, cfg_in[`MAP_CK_DLY]};
   wire        int_tick = mclk_edge_in & (dcnt == cfg_in[`MAP_CK_DIV]);
   wire        ext_tick = pol ? (bf_d & ~bf) : (~bf_d & bf);
   wire        tick = en_in & (cfg_in[`MAP_CK_INTB] ? int_tick : ext_tick);
   wire        fa = ff ^ cfg_in[`MAP_CK_FPOL];
   wire        ext_start = tick & fa & ~fa_d;
   wire        int_start = tick & ((pos == last) | ~run) & (go_in | (slots != 6'h01));
   wire        start = intf ? int_start : ext_start;
   wire        bit_wrap = (bitc == size - 6'h01);
   wire [5:0]  nbit = start ? ((dly == 6'h00) ? 6'h00 : size - dly)
                     : (bit_wrap ? 6'h00 : bitc + 6'h01);
   wire [12:0] half = ({1'b0, cfg_in[`MAP_CK_DIV]} + 13'h0001) >> 1;

   // Pin synchronisers; a level counts once the second and third stages agree.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bs   <= 3'h0;
         fsy  <= 3'h0;
         bf   <= 1'b0;
         bf_d <= 1'b0;
         ff   <= 1'b0;
      end else begin
         bs   <= {bs[1:0], bclk_pin_in};
         fsy  <= {fsy[1:0], fs_pin_in};
         bf_d <= bf;
         if (bs[2] == bs[1]) begin
            bf <= bs[2];
         end
         if (fsy[2] == fsy[1]) begin
            ff <= fsy[2];
         end
      end
   end

   // Divider, frame position and slot counters.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dcnt          <= 12'h000;
         pos           <= 10'h000;
         bitc          <= 6'h00;
         run           <= 1'b0;
         lock          <= 1'b0;
         fa_d          <= 1'b0;
         bclk_out      <= 1'b0;
         bclk_oe_n_out <= 1'b1;
         fs_out        <= 1'b0;
         fs_oe_n_out   <= 1'b1;
         slot_evt_out  <= 1'b0;
         err_out       <= 1'b0;
      end else begin
         // Master clock divided by the field value plus one.
         if (!en_in) begin
            dcnt <= 12'h000;
         end else if (mclk_edge_in) begin
            dcnt <= int_tick ? 12'h000 : dcnt + 12'h001;
         end
         // Pin drives only with an internal source; pol inverts.
         bclk_out      <= ({1'b0, dcnt} < half) ^ pol;
         bclk_oe_n_out <= ~(en_in & cfg_in[`MAP_CK_INTB]);
         fs_oe_n_out   <= ~(en_in & intf);
         // Bit or slot long frame sync with selectable edge.
         fs_out <= cfg_in[`MAP_CK_FPOL] ^ (run & (cfg_in[`MAP_CK_FLEN] ?
                   (pos < {4'h0, size}) : (pos == 10'h000)));
         slot_evt_out <= 1'b0;
         err_out      <= 1'b0;
         if (!en_in) begin
            run  <= 1'b0;
            lock <= 1'b0;
         end else if (tick) begin
            fa_d <= fa;
            // An external sync off the expected frame boundary is an error.
            err_out <= ext_start & ~intf & lock & (pos != last);
            if (ext_start & ~intf) begin
               lock <= 1'b1;
            end
            if (start) begin
               pos <= 10'h000;
               run <= 1'b1;
            end else if (pos == last) begin
               pos <= 10'h000;
               // Burst frames start only when data wait.
               run <= ~intf;
            end else begin
               pos <= pos + 10'h001;
            end
            // Data lag the frame sync by 0 to 3 bits.
            if (start | run) begin
               bitc <= nbit;
               // One service event at the first bit of every slot.
               slot_evt_out <= (nbit == 6'h00);
            end
         end
      end
   end
endmodule

// ### verilog/map_top.v
// Multichannel audio port: clocking, error supervision and data service.
// Assumes an APB master on MCLK_IN; pins are asynchronous to it.
`timescale 1ns/10ps
`include "map_defines.vh"
module map_top (
   input  wire        MCLK_IN,
   input  wire        RSTN_IN,
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output reg  [31:0] PRDATA_OUT,
   output reg         PREADY_OUT,
   output reg         PSLVERR_OUT,
   input  wire        TX_MCLK_PIN_IN,
   input  wire        RX_MCLK_PIN_IN,
   input  wire        TX_BCLK_PIN_IN,
   output wire        TX_BCLK_PIN_OUT,
   output wire        TX_BCLK_OE_N_OUT,
   input  wire        RX_BCLK_PIN_IN,
   output wire        RX_BCLK_PIN_OUT,
   output wire        RX_BCLK_OE_N_OUT,
   input  wire        TX_FS_PIN_IN,
   output wire        TX_FS_PIN_OUT,
   output wire        TX_FS_OE_N_OUT,
   input  wire        RX_FS_PIN_IN,
   output wire        RX_FS_PIN_OUT,
   output wire        RX_FS_OE_N_OUT,
   input  wire        MUTE_REQ_IN,
   output reg         MUTE_OUT,
   output reg         ERR_IRQ_OUT,
   output reg         TX_EVT_OUT,
   output reg         RX_EVT_OUT
);
   ////////////////////////////////////////////////////////////////////////////
   reg  [1:0]  ctrl_reg;
   reg  [31:0] txck_reg;
   reg  [31:0] rxck_reg;
   reg  [31:0] ser_reg;
   reg  [15:0] txlim_reg;
   reg  [15:0] rxlim_reg;
   reg  [5:0]  stat_reg;
   reg  [6:0]  mute_reg;
   reg  [5:0]  ien_reg;
   reg  [15:0] tx_full_reg;
   reg  [15:0] rx_full_reg;
   reg  [3:0]  tx_ptr_reg;
   reg  [3:0]  rx_ptr_reg;
   reg  [4:0]  win_reg;
   reg  [7:0]  tx_meas_reg;
   reg  [7:0]  rx_meas_reg;
   reg  [7:0]  tx_cnt_reg;
   reg  [7:0]  rx_cnt_reg;
   reg         tx_evt_reg;
   reg         rx_evt_reg;
   wire [2:0]  filt;
   wire [2:0]  filt_d;
   reg  [31:0] rd_next;
   reg         err_next;
   reg  [5:0]  stat_next;
   wire [2:0]  raw = {MUTE_REQ_IN, RX_MCLK_PIN_IN, TX_MCLK_PIN_IN};
   wire [2:0]  rise = filt & ~filt_d;
   wire [15:0] tx_mask;
   wire [15:0] rx_mask;
   wire [31:0] mem_rdata;
   wire        tx_slot;
   wire        rx_slot;
   wire        tx_perr;
   wire        rx_perr;

   ////////////////////////////////////////////////////////////////////////////
   // Three-stage synchronisers for master clocks and the mute request.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_sync
         reg [4:0] s;  // Stages 0 to 2 sample, 3 is the level, 4 its delay.
         always @(posedge MCLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               s <= 5'h00;
            end else begin
               s[2:0] <= {s[1:0], raw[g]};
               s[4]   <= s[3];
               if (s[2] == s[1]) begin
                  s[3] <= s[2];
               end
            end
         end
         assign filt[g]   = s[3];
         assign filt_d[g] = s[4];
      end
      // Serializer roles, two bits each: off, transmit or receive.
      for (g = 0; g < 16; g = g + 1) begin : g_role
         assign tx_mask[g] = (ser_reg[2*g+1:2*g] == `MAP_SER_TX);
         assign rx_mask[g] = (ser_reg[2*g+1:2*g] == `MAP_SER_RX);
      end
   endgenerate

   // First serializer of the mask at or above start, wrapping past 15.
   function [3:0] first_from;
      input [15:0] mask;
      input [3:0]  start;
      integer      k;
      reg     [3:0] j;
      begin
         first_from = start;
         for (k = 15; k >= 0; k = k - 1) begin
            j = start + k[3:0];
            if (mask[j]) begin
               first_from = j;
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Transmit and receive clock generators; only transmit bursts wait for data.
   map_clkgen u_txck (
      .clk_in        (MCLK_IN),
      .rst_n_in      (RSTN_IN),
      .en_in         (ctrl_reg[0]),
      .mclk_edge_in  (rise[0]),
      .cfg_in        (txck_reg),
      .go_in         (|(tx_full_reg & tx_mask)),
      .bclk_pin_in   (TX_BCLK_PIN_IN),
      .fs_pin_in     (TX_FS_PIN_IN),
      .bclk_out      (TX_BCLK_PIN_OUT),
      .bclk_oe_n_out (TX_BCLK_OE_N_OUT),
      .fs_out        (TX_FS_PIN_OUT),
      .fs_oe_n_out   (TX_FS_OE_N_OUT),
      .slot_evt_out  (tx_slot),
      .err_out       (tx_perr)
   );

   map_clkgen u_rxck (
      .clk_in        (MCLK_IN),
      .rst_n_in      (RSTN_IN),
      .en_in         (ctrl_reg[1]),
      .mclk_edge_in  (rise[1]),
      .cfg_in        (rxck_reg),
      .go_in         (1'b1),
      .bclk_pin_in   (RX_BCLK_PIN_IN),
      .fs_pin_in     (RX_FS_PIN_IN),
      .bclk_out      (RX_BCLK_PIN_OUT),
      .bclk_oe_n_out (RX_BCLK_OE_N_OUT),
      .fs_out        (RX_FS_PIN_OUT),
      .fs_oe_n_out   (RX_FS_OE_N_OUT),
      .slot_evt_out  (rx_slot),
      .err_out       (rx_perr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB decode: one wait state, so every access completes on its second
   // access cycle and the buffer store has time to deliver read data.
   wire        acc = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
   wire        done = PSEL_IN & PENABLE_IN & PREADY_OUT;
   wire        wr = done & PWRITE_IN;
   wire        rd = done & ~PWRITE_IN;
   wire        buf_hit = (PADDR_IN[11:6] == `MAP_BUF_PAGE);
   // Low address bits play no part in the data port.
   wire        dp_hit = (PADDR_IN[11:8] == `MAP_DP_PAGE);
   wire [3:0]  tx_cur = first_from(tx_mask, tx_ptr_reg);
   wire [3:0]  rx_cur = first_from(rx_mask, rx_ptr_reg);
   wire [3:0]  bidx = PADDR_IN[5:2];
   wire        dp_bad = dp_hit & (PWRITE_IN ? ~|tx_mask : ~|rx_mask);
   wire        mem_we = wr & (buf_hit | (dp_hit & ~dp_bad));
   wire [3:0]  mem_wa = buf_hit ? bidx : tx_cur;
   wire [3:0]  mem_ra = buf_hit ? bidx : rx_cur;
   wire [15:0] one_w = 16'h0001 << mem_wa;
   wire [15:0] one_r = 16'h0001 << mem_ra;
   wire [15:0] tx_set = mem_we ? (one_w & tx_mask) : 16'h0000;
   wire [15:0] rx_clr = (rd & (buf_hit | (dp_hit & ~dp_bad))) ? one_r : 16'h0000;
   wire        w1c = wr & (PADDR_IN == `MAP_OFF_STAT);

   // Processor sees each buffer at its own address.
   map_bufmem u_mem (
      .clk_in    (MCLK_IN),
      .we_in     (mem_we),
      .waddr_in  (mem_wa),
      .wdata_in  (PWDATA_IN),
      .raddr_in  (mem_ra),
      .rdata_out (mem_rdata)
   );

   // Read data and error answer, chosen in the first access cycle.
   always @* begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      if (buf_hit | dp_hit) begin
         rd_next  = mem_rdata;
         err_next = dp_bad;
      end else begin
         case (PADDR_IN)
            `MAP_OFF_CTRL:  rd_next = {30'h0, ctrl_reg};
            `MAP_OFF_TXCK:  rd_next = txck_reg;
            `MAP_OFF_RXCK:  rd_next = rxck_reg;
            `MAP_OFF_SER:   rd_next = ser_reg;
            `MAP_OFF_TXCHK: rd_next = {8'h00, tx_meas_reg, txlim_reg};
            `MAP_OFF_RXCHK: rd_next = {8'h00, rx_meas_reg, rxlim_reg};
            `MAP_OFF_STAT:  rd_next = {26'h0, stat_reg};
            `MAP_OFF_MUTE:  rd_next = {25'h0, mute_reg};
            `MAP_OFF_IEN:   rd_next = {26'h0, ien_reg};
            default:        err_next = 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // New error events; buffer state includes a same-cycle access.
   always @* begin
      stat_next = 6'h00;
      // A transmit slot with an empty active buffer is an underrun.
      stat_next[`MAP_ST_TXUR] = tx_slot & |(tx_mask & ~(tx_full_reg | tx_set));
      // A receive slot onto an unread buffer is an overrun.
      stat_next[`MAP_ST_RXOR] = rx_slot & |(rx_mask & rx_full_reg & ~rx_clr);
      stat_next[`MAP_ST_TXPR] = tx_perr;
      stat_next[`MAP_ST_RXPR] = rx_perr;
      // Window result outside the limits.
      stat_next[`MAP_ST_TXCK] = (win_reg == `MAP_WIN_LAST) &
         ((tx_cnt_reg < txlim_reg[`MAP_CHK_MIN]) | (tx_cnt_reg > txlim_reg[`MAP_CHK_MAX]));
      stat_next[`MAP_ST_RXCK] = (win_reg == `MAP_WIN_LAST) &
         ((rx_cnt_reg < rxlim_reg[`MAP_CHK_MIN]) | (rx_cnt_reg > rxlim_reg[`MAP_CHK_MAX]));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus registers, buffer flags, data port pointers and outputs.
   always @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ctrl_reg    <= 2'h0;
         txck_reg    <= 32'h0000_0000;
         rxck_reg    <= 32'h0000_0000;
         ser_reg     <= 32'h0000_0000;
         txlim_reg   <= `MAP_RST_CHK;
         rxlim_reg   <= `MAP_RST_CHK;
         stat_reg    <= 6'h00;
         mute_reg    <= `MAP_RST_MUTE;
         ien_reg     <= 6'h00;
         tx_full_reg <= 16'h0000;
         rx_full_reg <= 16'h0000;
         tx_ptr_reg  <= 4'h0;
         rx_ptr_reg  <= 4'h0;
         tx_evt_reg  <= 1'b0;
         rx_evt_reg  <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         MUTE_OUT    <= 1'b0;
         ERR_IRQ_OUT <= 1'b0;
         TX_EVT_OUT  <= 1'b0;
         RX_EVT_OUT  <= 1'b0;
      end else begin
         PREADY_OUT <= acc;
         if (acc) begin
            PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : rd_next;
            PSLVERR_OUT <= err_next;
         end else if (done) begin
            PSLVERR_OUT <= 1'b0;
         end
         if (wr) begin
            case (PADDR_IN)
               `MAP_OFF_CTRL:  ctrl_reg <= PWDATA_IN[1:0];
               // Slot and frame fields steer the generators.
               `MAP_OFF_TXCK:  txck_reg <= PWDATA_IN & `MAP_CK_MASK;
               `MAP_OFF_RXCK:  rxck_reg <= PWDATA_IN & `MAP_CK_MASK;
               `MAP_OFF_SER:   ser_reg <= PWDATA_IN;
               `MAP_OFF_TXCHK: txlim_reg <= PWDATA_IN[15:0];
               `MAP_OFF_RXCHK: rxlim_reg <= PWDATA_IN[15:0];
               `MAP_OFF_MUTE:  mute_reg <= PWDATA_IN[6:0];
               `MAP_OFF_IEN:   ien_reg <= PWDATA_IN[5:0];
               default:        ctrl_reg <= ctrl_reg;
            endcase
         end
         // Flags stick until written one; a new event beats the clear.
         stat_reg <= (stat_reg & ~(w1c ? PWDATA_IN[5:0] : 6'h00)) | stat_next;
         // Hardware empties on a slot, a write refills; the write wins.
         tx_full_reg <= (tx_full_reg & ~(tx_slot ? tx_mask : 16'h0000)) | tx_set;
         // A read empties, a slot refills; the slot wins.
         rx_full_reg <= (rx_full_reg & ~rx_clr) | (rx_slot ? rx_mask : 16'h0000);
         // Each slot restarts the walk at serializer 0.
         if (tx_slot) begin
            tx_ptr_reg <= 4'h0;
         end else if (wr & dp_hit & ~dp_bad) begin
            tx_ptr_reg <= tx_cur + 4'h1;
         end
         // Reads walk receive serializers the same way.
         if (rx_slot) begin
            rx_ptr_reg <= 4'h0;
         end else if (rd & dp_hit & ~dp_bad) begin
            rx_ptr_reg <= rx_cur + 4'h1;
         end
         tx_evt_reg <= tx_slot;
         rx_evt_reg <= rx_slot;
         // Per-slot service requests for interrupt or DMA.
         TX_EVT_OUT <= tx_evt_reg;
         RX_EVT_OUT <= rx_evt_reg;
         // Mute on selected errors or request, level chosen.
         MUTE_OUT <= mute_reg[`MAP_MUTE_LVL] ^ ~(filt[2] |
                     |((stat_reg | stat_next) & mute_reg[5:0]));
         // Only enabled error flags reach the interrupt.
         ERR_IRQ_OUT <= |(stat_reg & ien_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Master clock rising edges counted over 32-cycle windows.
   always @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         win_reg     <= 5'h00;
         tx_cnt_reg  <= 8'h00;
         rx_cnt_reg  <= 8'h00;
         tx_meas_reg <= 8'h00;
         rx_meas_reg <= 8'h00;
      end else begin
         win_reg <= win_reg + 5'h01;
         if (win_reg == `MAP_WIN_LAST) begin
            tx_meas_reg <= tx_cnt_reg;
            rx_meas_reg <= rx_cnt_reg;
            tx_cnt_reg  <= {7'h00, rise[0]};
            rx_cnt_reg  <= {7'h00, rise[1]};
         end else begin
            tx_cnt_reg <= tx_cnt_reg + {7'h00, rise[0]};
            rx_cnt_reg <= rx_cnt_reg + {7'h00, rise[1]};
         end
      end
   end
endmodule

// ### verif/map_asserts.sv
// Checker for map_top: APB answer timing, address decode, mute and transmit slot events.
// Assumes it sees only the top ports; mute level is shadowed from APB writes.
`timescale 1ns/10ps
module map_asserts (
   input wire        MCLK_IN,
   input wire        RSTN_IN,
   input wire        PSEL_IN,
   input wire        PENABLE_IN,
   input wire        PWRITE_IN,
   input wire [11:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   input wire        PREADY_OUT,
   input wire        PSLVERR_OUT,
   input wire        MUTE_REQ_IN,
   input wire        MUTE_OUT,
   input wire        TX_EVT_OUT
);
   reg  lvl_reg;
   wire done = PSEL_IN & PENABLE_IN & PREADY_OUT;
   // Shadow of the programmed mute level, active high after reset.
   always @(posedge MCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN)
         lvl_reg <= 1'h1;
      else if (done && PWRITE_IN && PADDR_IN == 12'h01c)
         lvl_reg <= PWDATA_IN[6];
   end
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RSTN_IN);
   a_ready_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
      else $error("ready late");
   a_ready_idle: assert property (!(PSEL_IN && PENABLE_IN) |=> !PREADY_OUT)
      else $error("ready without access");
   a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready too long");
   a_reg_mapped: assert property (done && PADDR_IN[11:5] == 7'h00 |-> !PSLVERR_OUT)
      else $error("register refused");
   a_buf_mapped: assert property (done && PADDR_IN[11:6] == 6'h04 |-> !PSLVERR_OUT)
      else $error("buffer refused");
   a_bad_addr: assert property (done && PADDR_IN == 12'h040 |-> PSLVERR_OUT)
      else $error("unmapped accepted");
   a_mute_req: assert property (MUTE_REQ_IN [*8] |-> MUTE_OUT == lvl_reg)
      else $error("mute not asserted");
   a_evt_pulse: assert property (TX_EVT_OUT |=> !TX_EVT_OUT)
      else $error("event too long");
   c_evt: cover property (TX_EVT_OUT);
   c_mute: cover property (MUTE_REQ_IN [*8]);
   c_refused: cover property (done && PSLVERR_OUT);
endmodule
bind map_top map_asserts i_map_asserts (.*);

// ### verif/map_far.sv
// Far-side clock source: one master clock per direction.
// Assumes no far-side bit clock or frame sync activity is needed.
`timescale 1ns/10ps
module map_far (
   output reg tx_mclk_out,
   output reg rx_mclk_out
);
   // Periods of 8 and 16 system cycles give 4 and 2 edges per window.
   initial begin
      tx_mclk_out = 1'h0;
      rx_mclk_out = 1'h0;
      fork
         forever #200 tx_mclk_out = ~tx_mclk_out;
         forever #400 rx_mclk_out = ~rx_mclk_out;
      join
   end
endmodule

// ### verif/testbench.sv
// Bench driving the audio port over APB, far-side clocks from map_far.
// Assumes released bit clock and frame sync pins read low.
`timescale 1ns/10ps
module testbench;
   reg         clk = 1'h0, rstn = 1'h0, psel = 1'h0, pen = 1'h0, pw = 1'h0, mreq = 1'h0, er;
   reg  [11:0] pa = 12'h000;
   reg  [31:0] pd = 32'h0, rd;
   integer     err_total = 0, tests_run = 0;
   wire [31:0] prd;
   wire        rdy, slv, txm, rxm, tbo, tbe, rbo, rbe, tfo, tfe, rfo, rfe, mute, irq, tev, rev;
   map_far i_map_far (.tx_mclk_out(txm), .rx_mclk_out(rxm));
   map_top i_map_top (.MCLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
      .PSLVERR_OUT(slv), .TX_MCLK_PIN_IN(txm), .RX_MCLK_PIN_IN(rxm), .TX_BCLK_PIN_IN(~tbe & tbo),
      .TX_BCLK_PIN_OUT(tbo), .TX_BCLK_OE_N_OUT(tbe), .RX_BCLK_PIN_IN(~rbe & rbo),
      .RX_BCLK_PIN_OUT(rbo), .RX_BCLK_OE_N_OUT(rbe), .TX_FS_PIN_IN(~tfe & tfo), .TX_FS_PIN_OUT(tfo),
      .TX_FS_OE_N_OUT(tfe), .RX_FS_PIN_IN(~rfe & rfo), .RX_FS_PIN_OUT(rfo), .RX_FS_OE_N_OUT(rfe),
      .MUTE_REQ_IN(mreq), .MUTE_OUT(mute), .ERR_IRQ_OUT(irq), .TX_EVT_OUT(tev), .RX_EVT_OUT(rev));
   ////////////////////////////////////////////////////////////////////////////
   // Clock, then a watchdog that cuts a hang short.
   initial forever #25 clk = ~clk;
   initial begin
      #4000000 err_total = err_total + 1;
      complete_run;
   end
   // Compares a seen value with the expected one and counts both.
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // One APB transfer, held until ready is sampled high at a rising edge.
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk) {psel, pw, pa, pd} <= {1'h1, w, a, d};
         @(posedge clk) pen <= 1'h1;
         @(posedge clk);
         while (rdy !== 1'h1) @(posedge clk);
         {rd, er} = {prd, slv};
         {psel, pen} <= 2'h0;
      end
   endtask
   task rchk(input [11:0] a, input [31:0] e);
      begin
         apb(1'h0, a, 32'h0);
         chk(rd, e);
      end
   endtask
   // Reset values, measured counts and a refused address.
   task t_regs;
      begin
         rchk(12'h01c, 32'h40);
         rchk(12'h010, 32'h4ff00);
         rchk(12'h014, 32'h2ff00);
         rchk(12'h040, 32'h0);
         chk(er, 1'h1);
         $display("regs done");
      end
   endtask
   // Clock range error drives mute low and the interrupt, holds, then clears.
   task t_err;
      begin
         apb(1'h1, 12'h01c, 32'h10);
         apb(1'h1, 12'h020, 32'h10);
         apb(1'h1, 12'h010, 32'hff05);
         repeat (80) @(posedge clk);
         apb(1'h1, 12'h010, 32'hff00);
         repeat (80) @(posedge clk);
         rchk(12'h018, 32'h10);
         @(negedge clk);
         chk({mute, irq}, 2'h1);
         apb(1'h1, 12'h018, 32'h10);
         repeat (4) @(negedge clk);
         chk({mute, irq}, 2'h2);
         @(posedge clk) mreq <= 1'h1;
         repeat (10) @(negedge clk);
         chk(mute, 1'h0);
         @(posedge clk) mreq <= 1'h0;
         $display("errors done");
      end
   endtask
   // Data port order with skipped serializers and ignored low address bits.
   task t_dport;
      begin
         apb(1'h1, 12'h200, 32'hd0);
         chk(er, 1'h1);
         apb(1'h1, 12'h00c, 32'h864);
         apb(1'h1, 12'h108, 32'hc2);
         apb(1'h1, 12'h114, 32'hc5);
         apb(1'h1, 12'h2fc, 32'hd1);
         apb(1'h1, 12'h210, 32'hd3);
         rchk(12'h104, 32'hd1);
         rchk(12'h10c, 32'hd3);
         rchk(12'h2a8, 32'hc2);
         rchk(12'h204, 32'hc5);
         $display("data port done");
      end
   endtask
   // Internal clocks and syncs produce slot events, then underrun and overrun.
   task t_evt;
      begin
         apb(1'h1, 12'h004, 32'h25000);
         apb(1'h1, 12'h008, 32'h27000);
         apb(1'h1, 12'h000, 32'h3);
         @(negedge clk);
         while (tev !== 1'h1) @(negedge clk);
         @(negedge clk);
         chk({tev, tfo, tfe, tbe, tbo}, 5'h08);
         while (rev !== 1'h1) @(negedge clk);
         @(negedge clk);
         chk({rev, rbo, rfe, rbe}, 4'h4);
         repeat (600) @(posedge clk);
         rchk(12'h018, 32'h3);
         apb(1'h1, 12'h000, 32'h0);
         $display("events done");
      end
   endtask
   // Counts, verdict and the end of the run.
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Reset for 16 cycles, let the measurement windows settle, run the tests.
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'h1;
      repeat (200) @(posedge clk);
      t_regs;
      t_err;
      t_dport;
      t_evt;
      complete_run;
   end
endmodule
